/* verilog/add_shift_defs.svh */
/*
  Constants of the add and shift datapath: bus offsets, opcode patterns,
  field positions and register indices. Assumes an AHB-Lite register bus.
*/
// Summary of operation
// - Immediate shift type 00 gives logical left by the five-bit literal.
// - Types 01 and 10 treat a literal of 00000 as a shift by 32.
// - Type 11 is never decoded as an immediate shift; the helper maps literal 00000 to extended rotate by 1, else rotate right.
// - Register shift types map 00 left, 01 right, 10 arithmetic, 11 rotate.
// - Zero shift amount passes the value and the incoming carry through.
// - Extended rotate is used only by one, carry enters at the top.
// - Only the three immediate and four register shifts shift; all others use left by zero.
// - Offset address is base plus or minus offset; base stays unchanged.
// - No exclusive memory access operations exist.
// - Add-with-carry adds both registers and the carry flag.
// - Flag-setting adds load negative, zero, carry and overflow.
// - Conditional block test is always false, so those forms set flags.
// - Three-bit literal add zero-extends 0-7 with carry-in zero.
// - Eight-bit literal add zero-extends 0-255 into the same register.
// - Three- and eight-bit literal adds use carry-in zero and update all four flags.
// - Three-register add uses an unshifted operand and sets flags.
// - High-register add: four-bit fields, no flags, 1101 means stack form.
// - High-register add with both operands 15 is treated as invalid.
// - Stack plus eight-bit literal scales by four up to 1020, no flags.
// - Stack adjust adds literal times four to register 13, no flags.
`ifndef ADD_SHIFT_DEFS_SVH
`define ADD_SHIFT_DEFS_SVH
`define OFS_INSTR 8'h00
`define OFS_FLAGS 8'h04
`define OFS_MEMCTL 8'h08
`define OFS_MEMADDR 8'h0C
`define OFS_STATUS 8'h10
`define OFS_REGFILE 8'h40
`define OFS_REGMASK 8'hC0
`define OP_ADC 10'h105
`define OP_ADD_THREE_BIT_LITERAL 7'h0E
`define OP_ADD_EIGHT_BIT_LITERAL 5'h06
`define OP_ADD_REG3 7'h0C
`define OP_ADD_HI 8'h44
`define OP_SP_EIGHT_BIT_LITERAL 5'h15
`define OP_SP_ADJ 9'h160
`define OP_SH_IMM 3'h0
`define OP_SH_REG 6'h10
`define SH_REG_LSL 4'h2
`define SH_REG_LSR 4'h3
`define SH_REG_ASR 4'h4
`define SH_REG_ROR 4'h7
`define TYPE_LSL 2'h0
`define TYPE_LSR 2'h1
`define TYPE_ASR 2'h2
`define TYPE_ROR 2'h3
`define LIT5_ZERO 5'h00
`define AMT_WORD 8'h20
`define AMT_ONE 8'h01
`define AMT_ZERO 8'h00
`define WORD_BITS 6'h20
`define REG_SP 4'hD
`define REG_PC 4'hF
`define FLAGS_RESET 4'h0
`define ST_INVALID 0
`define ST_PCLOAD 1
`define ST_SPFORM 2
`define ST_FLAGSET 3
`define MC_BASE_LO 0
`define MC_INDEX_LO 4
`define MC_USE_IMM 8
`define MC_SUB 9
`define MC_IMM_LO 10
`endif

/* verilog/add_shift_pkg.sv */
/*
  Types shared by the add and shift datapath. Needs add_shift_defs.svh
  for no constants; types only.
*/
package add_shift_pkg;
  typedef enum logic [2:0] {SK_LSL, SK_LSR, SK_ASR, SK_ROR, SK_RRX} shift_kind_t;
  typedef struct packed {
    shift_kind_t kind;
    logic [7:0] amount;
  } shift_req_t;
  typedef struct packed {
    logic [31:0] res;
    logic carry;
  } shift_out_t;
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_t;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} phase_t;
endpackage

/* verilog/add_and_shift_datapath.sv */
/*
  Add and shift datapath of a 32-bit core with sixteen registers and
  condition flags, executing 16-bit add and shift encodings written over
  an AHB-Lite slave port. Assumes one master, word transfers only.
*/
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "add_shift_defs.svh"

module add_and_shift_datapath
  import add_shift_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata // Read data
);

  // ==========================================================
  // Shift helpers
  // ==========================================================
  function automatic shift_req_t dec_imm_shift(input logic [1:0] typ, input logic [4:0] lit);
    shift_req_t r;
    r.kind = SK_LSL;
    r.amount = {3'h0, lit};
    case (typ)
      `TYPE_LSL: r.kind = SK_LSL;
      `TYPE_LSR:
      begin
        r.kind = SK_LSR;
        if (lit == `LIT5_ZERO) r.amount = `AMT_WORD;
      end
      `TYPE_ASR:
      begin
        r.kind = SK_ASR;
        if (lit == `LIT5_ZERO) r.amount = `AMT_WORD;
      end
      default:
      begin
        if (lit == `LIT5_ZERO)
        begin
          r.kind = SK_RRX;
          r.amount = `AMT_ONE;
        end
        else
          r.kind = SK_ROR;
      end
    endcase
    return r;
  endfunction

  // Never yields the extended rotate
  function automatic shift_kind_t dec_reg_shift(input logic [1:0] typ);
    shift_kind_t k;
    case (typ)
      `TYPE_LSL: k = SK_LSL;
      `TYPE_LSR: k = SK_LSR;
      `TYPE_ASR: k = SK_ASR;
      default: k = SK_ROR;
    endcase
    return k;
  endfunction

  // Amounts above 32 fall out of the wide shifts naturally: all zeros or all sign
  function automatic shift_out_t shift_c(input logic [31:0] v, input shift_req_t rq, input logic cin);
    logic [32:0] t;
    logic [4:0] n;
    shift_out_t o;
    t = '0;
    n = rq.amount[4:0];
    o.res = v;
    o.carry = cin;
    if (rq.amount != `AMT_ZERO)
    begin
      case (rq.kind)
        SK_LSL:
        begin
          t = {1'b0, v} << rq.amount;
          o.res = t[31:0];
          o.carry = t[32];
        end
        SK_LSR:
        begin
          t = {v, 1'b0} >> rq.amount;
          o.res = t[32:1];
          o.carry = t[0];
        end
        SK_ASR:
        begin
          t = 33'($signed({v, 1'b0}) >>> rq.amount);
          o.res = t[32:1];
          o.carry = t[0];
        end
        SK_ROR:
        begin
          if (n != 5'h00)
            o.res = (v >> n) | (v << (6'(`WORD_BITS) - {1'b0, n}));
          o.carry = o.res[31];
        end
        SK_RRX:
        begin
          o.res = {cin, v[31:1]};
          o.carry = v[0];
        end
        default:
        begin
          o.res = v;
          o.carry = cin;
        end
      endcase
    end
    return o;
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic [31:0] regFile [16];
  flags_t flags;
  logic [3:0] status;
  logic [17:0] memCtl;
  logic [31:0] memAddr;
  logic [15:0] lastInstr;
  phase_t phase;
  logic [7:0] dataAddr;

  // ==========================================================
  // Bus decode
  // ==========================================================
  wire logic busReq = hsel && htrans[1] && hready;
  wire logic wrPhase = (phase == PH_WRITE);
  wire logic instrWr = wrPhase && (dataAddr == `OFS_INSTR);
  wire logic flagsWr = wrPhase && (dataAddr == `OFS_FLAGS);
  wire logic memCtlWr = wrPhase && (dataAddr == `OFS_MEMCTL);
  wire logic regWin = (dataAddr & `OFS_REGMASK) == `OFS_REGFILE;
  wire logic swRegWr = wrPhase && regWin;
  wire logic [3:0] swRegIdx = dataAddr[5:2];

  // ==========================================================
  // Instruction decode
  // ==========================================================
  wire logic [15:0] ins = hwdata[15:0];
  wire logic isAdc = ins[15:6] == `OP_ADC;
  wire logic isAddImm3 = ins[15:9] == `OP_ADD_THREE_BIT_LITERAL;
  wire logic isAddImm8 = ins[15:11] == `OP_ADD_EIGHT_BIT_LITERAL;
  wire logic isAddReg3 = ins[15:9] == `OP_ADD_REG3;
  wire logic isAddHi = ins[15:8] == `OP_ADD_HI;
  wire logic isSpImm8 = ins[15:11] == `OP_SP_EIGHT_BIT_LITERAL;
  wire logic isSpAdj = ins[15:7] == `OP_SP_ADJ;
  wire logic isShImm = (ins[15:13] == `OP_SH_IMM) && (ins[12:11] != `TYPE_ROR);
  wire logic [3:0] shRegOp = ins[9:6];
  wire logic isShReg = (ins[15:10] == `OP_SH_REG) && (shRegOp == `SH_REG_LSL || shRegOp == `SH_REG_LSR
    || shRegOp == `SH_REG_ASR || shRegOp == `SH_REG_ROR);
  wire logic [1:0] shRegType = (shRegOp == `SH_REG_LSL) ? `TYPE_LSL : (shRegOp == `SH_REG_LSR) ? `TYPE_LSR
    : (shRegOp == `SH_REG_ASR) ? `TYPE_ASR : `TYPE_ROR;

  // High-register fields; 1101 in either picks the stack pointer form
  wire logic [3:0] hiDest = {ins[7], ins[2:0]};
  wire logic [3:0] hiSrc = ins[6:3];
  wire logic hiSpForm = isAddHi && (hiDest == `REG_SP || hiSrc == `REG_SP);
  wire logic hiBothPc = isAddHi && hiDest == `REG_PC && hiSrc == `REG_PC;

  // Conditional blocks are unsupported, so the in-block test never holds
  wire logic condBlockTest = 1'b0;
  wire logic isAdd = isAdc || isAddImm3 || isAddImm8 || isAddReg3 || isAddHi || isSpImm8 || isSpAdj;
  wire logic isShift = isShImm || isShReg;
  wire logic known = (isAdd || isShift) && !hiBothPc;
  wire logic doExec = instrWr && known;
  wire logic setNzcv = (isAdc || isAddImm3 || isAddImm8 || isAddReg3) && !condBlockTest;
  wire logic setNzc = isShift && !condBlockTest;

  // ==========================================================
  // Operand selection
  // ==========================================================
  wire logic [3:0] mIdx = isShReg ? {1'b0, ins[2:0]} : isAddReg3 ? {1'b0, ins[8:6]}
    : isAddHi ? hiSrc : {1'b0, ins[5:3]};
  wire logic [3:0] nIdx = isAdc ? {1'b0, ins[2:0]} : isAddImm8 ? {1'b0, ins[10:8]}
    : isAddHi ? hiDest : (isSpImm8 || isSpAdj) ? `REG_SP : {1'b0, ins[5:3]};
  wire logic [3:0] dIdx = (isAddImm8 || isSpImm8) ? {1'b0, ins[10:8]} : isAddHi ? hiDest
    : isSpAdj ? `REG_SP : {1'b0, ins[2:0]};
  wire logic [31:0] mVal = regFile[mIdx];
  wire logic [31:0] nVal = regFile[nIdx];
  wire logic [7:0] regAmount = regFile[{1'b0, ins[5:3]}][7:0];

  // Non-shift instructions go through the shifter as left by zero
  wire shift_req_t shReq = isShImm ? dec_imm_shift(ins[12:11], ins[10:6])
    : isShReg ? shift_req_t'{kind: dec_reg_shift(shRegType), amount: regAmount}
    : shift_req_t'{kind: SK_LSL, amount: `AMT_ZERO};
  wire shift_out_t shOut = shift_c(mVal, shReq, flags.c);

  wire logic [31:0] opB = isAddImm3 ? {29'h0, ins[8:6]}
    : isAddImm8 ? {24'h0, ins[7:0]}
    : isSpImm8 ? {22'h0, ins[7:0], 2'b00}
    : isSpAdj ? {23'h0, ins[6:0], 2'b00}
    : shOut.res;
  wire logic addCin = isAdc ? flags.c : 1'b0;
  wire logic [32:0] sum = {1'b0, nVal} + {1'b0, opB} + {32'h0, addCin};
  wire logic [31:0] addRes = sum[31:0];
  wire logic addOvf = (nVal[31] == opB[31]) && (addRes[31] != nVal[31]);
  wire logic [31:0] result = isShift ? shOut.res : addRes;
  wire flags_t nextFlags = setNzcv ? flags_t'{n: result[31], z: result == 32'h0, c: sum[32], v: addOvf}
    : setNzc ? flags_t'{n: result[31], z: result == 32'h0, c: shOut.carry, v: flags.v}
    : flags;

  // ==========================================================
  // Offset address generation
  // ==========================================================
  // No exclusive monitor: every access computed here is an ordinary one
  wire logic [17:0] next_memCtl = hwdata[17:0];
  wire logic [31:0] mcBase = regFile[next_memCtl[`MC_BASE_LO +: 4]];
  wire logic [31:0] mcOffset = next_memCtl[`MC_USE_IMM] ? {24'h0, next_memCtl[`MC_IMM_LO +: 8]}
    : regFile[next_memCtl[`MC_INDEX_LO +: 4]];
  wire logic [31:0] next_memAddr = next_memCtl[`MC_SUB] ? mcBase - mcOffset : mcBase + mcOffset;

  // ==========================================================
  // Read mux
  // ==========================================================
  wire logic [31:0] rdData = regWin ? regFile[swRegIdx]
    : (dataAddr == `OFS_INSTR) ? {16'h0, lastInstr}
    : (dataAddr == `OFS_FLAGS) ? {28'h0, flags}
    : (dataAddr == `OFS_MEMCTL) ? {14'h0, memCtl}
    : (dataAddr == `OFS_MEMADDR) ? memAddr
    : (dataAddr == `OFS_STATUS) ? {28'h0, status}
    : 32'h0;

  // ==========================================================
  // Bus phase tracking
  // ==========================================================
  // Reads take one wait state so that data reflect a write just before them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase <= PH_IDLE;
      dataAddr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
    end
    else if (phase == PH_READ && !hreadyout)
    begin
      hrdata <= rdData;
      hreadyout <= 1'b1;
      phase <= PH_IDLE;
    end
    else
    begin
      phase <= !busReq ? PH_IDLE : hwrite ? PH_WRITE : PH_READ;
      dataAddr <= haddr[7:0];
      hreadyout <= !(busReq && !hwrite);
    end
  end

  always_ff @(posedge core_clk)
  begin
    hresp <= 1'b0;
  end

  // ==========================================================
  // Architectural state
  // ==========================================================
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        regFile[i] <= 32'h0;
    end
    else if (doExec)
      regFile[dIdx] <= result;
    else if (swRegWr)
      regFile[swRegIdx] <= hwdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      flags <= `FLAGS_RESET;
    else if (doExec)
      flags <= nextFlags;
    else if (flagsWr)
      flags <= hwdata[3:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      status <= 4'h0;
      lastInstr <= 16'h0;
    end
    else if (instrWr)
    begin
      lastInstr <= ins;
      status[`ST_INVALID] <= !known;
      status[`ST_PCLOAD] <= doExec && isAddHi && dIdx == `REG_PC;
      status[`ST_SPFORM] <= doExec && hiSpForm;
      status[`ST_FLAGSET] <= doExec && (setNzcv || setNzc);
    end
  end

  // Base register is only read here, never written back
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      memCtl <= 18'h0;
      memAddr <= 32'h0;
    end
    else if (memCtlWr)
    begin
      memCtl <= next_memCtl;
      memAddr <= next_memAddr;
    end
  end

endmodule // add_and_shift_datapath

/* verification/add_shift_checker.sv */
/*
  Bus checker of the add and shift datapath.
  Assumes one master and hready tied to hreadyout.
*/
`timescale 1ns/1ps
`include "add_shift_defs.svh"

module add_shift_checker
(
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata // Read data
);
  // ========================================
  // Read tracking
  logic rdPend;
  logic [7:0] rdAddr;
  wire addrRd = hsel && htrans[1] && hready && !hwrite;
  wire addrWr = hsel && htrans[1] && hready && hwrite;
  wire rdEnd = rdPend && hreadyout;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdPend <= 1'b0;
    else if (hready)
      rdPend <= addrRd;
  end
  // Offset is only needed while a read waits, so no reset
  always_ff @(posedge core_clk)
  begin
    if (hready)
      rdAddr <= haddr[7:0];
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (addrRd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (addrWr |=> hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_reset_clear: assert property ($fell(rst) |-> hreadyout && hrdata == 32'h0)
    else $error("outputs not cleared");
  a_flags_width: assert property (rdEnd && rdAddr == `OFS_FLAGS |-> hrdata[31:4] == 28'h0)
    else $error("flags read too wide");
  a_instr_width: assert property (rdEnd && rdAddr == `OFS_INSTR |-> hrdata[31:16] == 16'h0)
    else $error("instruction read too wide");
  a_unmapped_zero: assert property (rdEnd && rdAddr == 8'h30 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (rdEnd && rdAddr == `OFS_FLAGS);
  cover property (addrWr && haddr[7:0] == `OFS_INSTR);
  cover property (addrWr ##1 addrRd);
endmodule // add_shift_checker

bind add_and_shift_datapath add_shift_checker chk_u (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

/* verification/add_and_shift_datapath_test.sv */
/*
  Self-checking bench of the add and shift datapath as sole bus master.
  Assumes the slave's hreadyout is the bus hready.
*/
`timescale 1ns/1ps
`include "add_shift_defs.svh"

module add_and_shift_datapath_test;
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] a;
    logic [31:0] b;
    logic [3:0] fin;
    logic [3:0] dst;
    logic [3:0] fout;
    logic [31:0] res;
  } row_t;
  logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int failures, checksDone;
  row_t rows [15];
  assign hready = hreadyout;
  add_and_shift_datapath dut_u (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
  // ========================================
  // Bus tasks
  // Ready and read data are taken at the rising edge itself; only the watchdog ends a hung wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    checksDone++;
    if (q !== e)
    begin
      failures++;
      $display("[FAIL] %0t read %h got %h want %h", $time, a, q, e);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    #100000;
    failures++;
    test_done();
  end
  // ========================================
  // Sequence
  initial
  begin
    failures = 0;
    checksDone = 0;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    rows = '{
      {16'h4151, 32'hFFFFFFFF, 32'h0, 4'h2, 4'h1, 4'h6, 32'h0},
      {16'h1DCB, 32'h7FFFFFF9, 32'h0, 4'h2, 4'h3, 4'h9, 32'h80000000},
      {16'h31FF, 32'h1, 32'h0, 4'h2, 4'h1, 4'h0, 32'h100},
      {16'h188B, 32'h80000000, 32'h80000000, 4'h0, 4'h3, 4'h7, 32'h0},
      {16'h4411, 32'hFFFFFFFF, 32'h2, 4'h5, 4'h1, 4'h5, 32'h1},
      {16'hABFF, 32'h0, 32'h0, 4'hA, 4'h3, 4'hA, 32'h13FC},
      {16'h0013, 32'h0, 32'h80000001, 4'h3, 4'h3, 4'hB, 32'h80000001},
      {16'h0813, 32'h0, 32'h80000000, 4'h0, 4'h3, 4'h6, 32'h0},
      {16'h1013, 32'h0, 32'h80000000, 4'h0, 4'h3, 4'hA, 32'hFFFFFFFF},
      {16'h1053, 32'h0, 32'h3, 4'h0, 4'h3, 4'h2, 32'h1},
      {16'h4091, 32'h1, 32'h20, 4'h0, 4'h1, 4'h6, 32'h0},
      {16'h40D1, 32'h80000000, 32'h1F, 4'h0, 4'h1, 4'h0, 32'h1},
      {16'h4111, 32'h80000000, 32'h0, 4'h2, 4'h1, 4'hA, 32'h80000000},
      {16'h41D1, 32'h1, 32'h1, 4'h0, 4'h1, 4'hA, 32'h80000000},
      {16'hB07F, 32'h0, 32'h0, 4'h3, 4'hD, 4'h3, 32'h11FC}
    };
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(`OFS_FLAGS, 32'h0);
    chk(`OFS_REGFILE + 8'h4, 32'h0);
    wr(`OFS_REGFILE + 8'h34, 32'h1000);
    // Operands reloaded each row so rows stay independent; the stack row that moves R13 is last
    foreach (rows[i])
    begin
      wr(`OFS_REGFILE + 8'h4, rows[i].a);
      wr(`OFS_REGFILE + 8'h8, rows[i].b);
      wr(`OFS_FLAGS, {28'h0, rows[i].fin});
      wr(`OFS_INSTR, {16'h0, rows[i].op});
      chk(`OFS_REGFILE + {2'h0, rows[i].dst, 2'h0}, rows[i].res);
      chk(`OFS_FLAGS, {28'h0, rows[i].fout});
    end
    wr(`OFS_REGFILE + 8'h4, 32'h100);
    wr(`OFS_REGFILE + 8'h8, 32'h4);
    wr(`OFS_MEMCTL, 32'h4301);
    chk(`OFS_MEMADDR, 32'hF0);
    chk(`OFS_REGFILE + 8'h4, 32'h100);
    wr(`OFS_MEMCTL, 32'h21);
    chk(`OFS_MEMADDR, 32'h104);
    wr(`OFS_FLAGS, 32'h5);
    wr(`OFS_INSTR, 32'h44FF);
    chk(`OFS_STATUS, 32'h1);
    chk(`OFS_FLAGS, 32'h5);
    wr(`OFS_INSTR, 32'h448F);
    chk(`OFS_STATUS, 32'h2);
    wr(`OFS_INSTR, 32'h4469);
    chk(`OFS_STATUS, 32'h4);
    chk(`OFS_FLAGS, 32'h5);
    wr(`OFS_INSTR, 32'h1DCB);
    chk(`OFS_STATUS, 32'h8);
    chk(8'h30, 32'h0);
    test_done();
  end
endmodule // add_and_shift_datapath_test
